// ==== pkg/gpio_pin_regs.svh ====
// Register offsets, field positions, reset values and timing counts for the pin block
`ifndef GPIO_PIN_REGS_SVH
`define GPIO_PIN_REGS_SVH

// Register map
`define GPIO_PIN_COUNT      40
`define GPIO_CTRL_BASE      16'h1700
`define GPIO_CTRL_LAST      16'h174F
`define GPIO_DBCFG_ADDR     16'h1AC0
`define GPIO_FLAG_ADDR0     16'h1B00
`define GPIO_FLAG_ADDR1     16'h1B01
`define GPIO_FLAG_ADDR2     16'h1B02

// First control word fields
`define GPIO_LVL_BIT        15
`define GPIO_OD_BIT         14
`define GPIO_DB_BIT         13
`define GPIO_POL_BIT        12
`define GPIO_FN_MSB         8

// Second control word fields
`define GPIO_DIR_BIT        15
`define GPIO_PU_BIT         14
`define GPIO_PD_BIT         13

// Reset values
`define GPIO_FN_RESET       9'h001
`define GPIO_LVL_RESET      1'b0
`define GPIO_OD_RESET       1'b0
`define GPIO_DB_RESET       1'b1
`define GPIO_POL_RESET      1'b0
`define GPIO_DIR_RESET      1'b1
`define GPIO_PU_RESET       1'b1
`define GPIO_PD_RESET       1'b1
`define GPIO_DBTIME_RESET   4'h0

// Timing
`define GPIO_CLK_HZ         125000000
`define GPIO_SLOW_HZ        32768
`define GPIO_SLOW_DIV       (`GPIO_CLK_HZ / `GPIO_SLOW_HZ)
`define GPIO_DB_TIME0_US    100
`define GPIO_DB_TIME1_US    1500
`define GPIO_DBTIME_MAX     4'hA
`define GPIO_US_PER_S       1000000

`endif

// ==== pkg/gpio_pin_pkg.sv ====
// Types shared by the pin control block
package gpio_pin_pkg;

  typedef enum logic [8:0] {
    FN_ALT   = 9'h000,
    FN_LOGIC = 9'h001,
    FN_DSP   = 9'h002,
    FN_IRQ1  = 9'h003,
    FN_IRQ2  = 9'h004
  } fn_code_t;

  typedef enum logic {
    DB_STABLE = 1'b0,
    DB_SETTLE = 1'b1
  } db_state_t;

  typedef logic [14:0] db_count_t;

endpackage

// ==== rtl/gpio_debounce.sv ====
// Debounce filter for one synchronised pin input
`timescale 1ns/1ps
module gpio_debounce (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               resetn_in,
  // Filter control
  input  wire logic               enable_in,
  input  wire logic               tick_in,
  input  wire gpio_pin_pkg::db_count_t period_in,
  // Levels
  input  wire logic               sample_in,
  output logic                    level_out
);

  gpio_pin_pkg::db_state_t state_reg;
  gpio_pin_pkg::db_state_t state_next;
  gpio_pin_pkg::db_count_t count_reg;
  gpio_pin_pkg::db_count_t count_next;
  logic                    level_reg;
  logic                    level_next;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    level_next = level_reg;
    if (!enable_in) begin
      level_next = sample_in;
      state_next = gpio_pin_pkg::DB_STABLE;
      count_next = '0;
    end else begin
      case (state_reg)
        gpio_pin_pkg::DB_STABLE: begin
          if (sample_in != level_reg) begin
            state_next = gpio_pin_pkg::DB_SETTLE;
            count_next = '0;
          end
        end
        gpio_pin_pkg::DB_SETTLE: begin
          // (R20) whole period unchanged
          if (sample_in == level_reg) begin
            state_next = gpio_pin_pkg::DB_STABLE;
          end else if (tick_in) begin
            // Counting one extra tick keeps the period a least time
            if (count_reg >= period_in) begin
              level_next = sample_in;
              state_next = gpio_pin_pkg::DB_STABLE;
            end else begin
              count_next = count_reg + 15'h0001;
            end
          end
        end
        default: state_next = gpio_pin_pkg::DB_STABLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_reg <= gpio_pin_pkg::DB_STABLE;
      count_reg <= '0;
      level_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  filter_pass_a: assert property ( // (R20)
    $changed(level_reg) && $past(enable_in) |->
      $past(state_reg == gpio_pin_pkg::DB_SETTLE && tick_in && count_reg >= period_in))
    else $error("debounced level moved before the period ran out");

  filter_bypass_a: assert property ( // (R3)
    !enable_in |=> level_reg == $past(sample_in))
    else $error("disabled filter did not follow its input");

endmodule // gpio_debounce

// ==== rtl/gpio_pin_control.sv ====
// Per-pin function, direction, level, drive, pull and edge flag control for 40 pins
// Function
// (R1) Every pin has its own function select
// (R2) Input level reads sampled pin, not inverted
// (R3) Debounce enable filters input from slow tick
// (R4) Rising and falling input edges raise events
// (R5) Edge flags latch, poll, drive interrupt
// (R6) Pull-up and pull-down enabled independently
// (R7) Both pulls enabled forms bus keeper
// (R8) Bus keeper active on all pins after reset
// (R9) Logic output drives written level bit
// (R10) Output level bit reads back zero
// (R11) Invert bit inverts selected output function
// (R12) Invert ignored for alternate and DSP codes
// (R13) Bit 14 selects CMOS or open drain
// (R14) Drive select ignored for alternate, DSP codes
// (R15) First control words 1700h-174Eh, level bit 15
// (R16) Software matches direction to function
// (R17) Debounce time codes 100us to 768ms
// (R18) Direction bit 1 input, ignored alt/DSP
// (R19) Function codes alt, logic, DSP, IRQ
// (R20) Filter passes level after full stable period
`timescale 1ns/1ps
`include "gpio_pin_regs.svh"
module gpio_pin_control (
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RESETN_IN,
  // Register access
  input  wire logic [15:0] REG_ADDR_IN,
  input  wire logic [15:0] REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  output logic      [15:0] REG_RDATA_OUT,
  output logic             REG_RVALID_OUT,
  // Pads
  input  wire logic [39:0] PIN_IN,
  output logic      [39:0] PIN_OUT,
  output logic      [39:0] PIN_OE_OUT,
  output logic      [39:0] PULL_UP_OUT,
  output logic      [39:0] PULL_DOWN_OUT,
  // Function sources
  input  wire logic [39:0] ALT_OUT_IN,
  input  wire logic [39:0] ALT_OE_IN,
  input  wire logic [39:0] DSP_OUT_IN,
  input  wire logic [39:0] DSP_OE_IN,
  input  wire logic [39:0] FUNC_SRC_IN,
  input  wire logic        IRQ2_IN,
  // Input levels and events
  output logic      [39:0] PIN_LEVEL_OUT,
  output logic             EDGE_IRQ_OUT
);

  localparam int NPIN = `GPIO_PIN_COUNT;

  // Pin index of a control word address
  function automatic logic [5:0] pin_index(input logic [15:0] addr);
    logic [15:0] off;
    off = addr - `GPIO_CTRL_BASE;
    return off[6:1];
  endfunction

  function automatic logic ctrl_hit(input logic [15:0] addr);
    return (addr >= `GPIO_CTRL_BASE) && (addr <= `GPIO_CTRL_LAST);
  endfunction

  // (R17) debounce code to slow ticks
  function automatic gpio_pin_pkg::db_count_t db_ticks(input logic [3:0] code);
    logic [63:0] us;
    logic [63:0] ticks;
    if (code == 4'h0 || code > `GPIO_DBTIME_MAX) begin
      us = 64'(`GPIO_DB_TIME0_US);
    end else begin
      us = 64'(`GPIO_DB_TIME1_US) << (code - 4'h1);
    end
    ticks = (us * 64'(`GPIO_SLOW_HZ) + 64'(`GPIO_US_PER_S) - 64'h1) / 64'(`GPIO_US_PER_S);
    return ticks[14:0];
  endfunction

  // Configuration state
  logic [8:0]  fn_reg   [NPIN];
  logic [8:0]  fn_next  [NPIN];
  logic [39:0] lvl_reg, lvl_next, od_reg, od_next, db_reg, db_next, pol_reg, pol_next;
  logic [39:0] dir_reg, dir_next, pu_reg, pu_next, pd_reg, pd_next;
  logic [3:0]  dbtime_reg, dbtime_next;
  logic [5:0]  widx;
  logic        whit;

  assign widx = pin_index(REG_ADDR_IN);
  assign whit = REG_WR_IN && ctrl_hit(REG_ADDR_IN);

  always_comb begin
    fn_next     = fn_reg;
    lvl_next    = lvl_reg;
    od_next     = od_reg;
    db_next     = db_reg;
    pol_next    = pol_reg;
    dir_next    = dir_reg;
    pu_next     = pu_reg;
    pd_next     = pd_reg;
    dbtime_next = dbtime_reg;
    // (R15) word pairs per pin
    if (whit && !REG_ADDR_IN[0]) begin
      lvl_next[widx]    = REG_WDATA_IN[`GPIO_LVL_BIT];
      od_next[widx]     = REG_WDATA_IN[`GPIO_OD_BIT];
      db_next[widx]     = REG_WDATA_IN[`GPIO_DB_BIT];
      pol_next[widx]    = REG_WDATA_IN[`GPIO_POL_BIT];
      fn_next[widx]     = REG_WDATA_IN[`GPIO_FN_MSB:0];
    end else if (whit) begin
      dir_next[widx]    = REG_WDATA_IN[`GPIO_DIR_BIT];
      pu_next[widx]     = REG_WDATA_IN[`GPIO_PU_BIT];
      pd_next[widx]     = REG_WDATA_IN[`GPIO_PD_BIT];
    end
    if (REG_WR_IN && REG_ADDR_IN == `GPIO_DBCFG_ADDR) begin
      dbtime_next = REG_WDATA_IN[3:0];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      for (int i = 0; i < NPIN; i++) begin
        fn_reg[i] <= `GPIO_FN_RESET;
      end
      lvl_reg    <= {NPIN{`GPIO_LVL_RESET}};
      od_reg     <= {NPIN{`GPIO_OD_RESET}};
      db_reg     <= {NPIN{`GPIO_DB_RESET}};
      pol_reg    <= {NPIN{`GPIO_POL_RESET}};
      dir_reg    <= {NPIN{`GPIO_DIR_RESET}};
      // (R8) keeper on at reset
      pu_reg     <= {NPIN{`GPIO_PU_RESET}};
      pd_reg     <= {NPIN{`GPIO_PD_RESET}};
      dbtime_reg <= `GPIO_DBTIME_RESET;
    end else begin
      fn_reg     <= fn_next;
      lvl_reg    <= lvl_next;
      od_reg     <= od_next;
      db_reg     <= db_next;
      pol_reg    <= pol_next;
      dir_reg    <= dir_next;
      pu_reg     <= pu_next;
      pd_reg     <= pd_next;
      dbtime_reg <= dbtime_next;
    end
  end

  // Slow tick divider
  logic [11:0] div_reg, div_next;
  logic        tick;

  assign tick = (div_reg == 12'(`GPIO_SLOW_DIV - 1));

  always_comb begin
    div_next = tick ? 12'h000 : div_reg + 12'h001;
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      div_reg <= 12'h000;
    end else begin
      div_reg <= div_next;
    end
  end

  // Input path: sync, filter, edges
  logic [39:0] sync1_reg, sync2_reg, level_in, prev_reg, flag_reg, flag_next, clr;
  gpio_pin_pkg::db_count_t period;

  assign period = db_ticks(dbtime_reg);

  // (R3) one filter per pin
  for (genvar g = 0; g < NPIN; g++) begin : g_db
    gpio_debounce gpio_debounce_i (
      .clk_in    (CLK_IN),
      .resetn_in (RESETN_IN),
      .enable_in (db_reg[g]),
      .tick_in   (tick),
      .period_in (period),
      .sample_in (sync2_reg[g]),
      .level_out (level_in[g])
    );
  end

  always_comb begin
    clr = 40'h00_0000_0000;
    if (REG_WR_IN && REG_ADDR_IN == `GPIO_FLAG_ADDR0) clr[15:0]  = REG_WDATA_IN;
    if (REG_WR_IN && REG_ADDR_IN == `GPIO_FLAG_ADDR1) clr[31:16] = REG_WDATA_IN;
    if (REG_WR_IN && REG_ADDR_IN == `GPIO_FLAG_ADDR2) clr[39:32] = REG_WDATA_IN[7:0];
    // (R4) both edges; (R5) set beats clear
    flag_next = (flag_reg & ~clr) | (level_in ^ prev_reg);
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      sync1_reg <= 40'h00_0000_0000;
      sync2_reg <= 40'h00_0000_0000;
      prev_reg  <= 40'h00_0000_0000;
      flag_reg  <= 40'h00_0000_0000;
    end else begin
      sync1_reg <= PIN_IN;
      sync2_reg <= sync1_reg;
      prev_reg  <= level_in;
      flag_reg  <= flag_next;
    end
  end

  assign PIN_LEVEL_OUT = level_in;
  assign EDGE_IRQ_OUT  = |flag_reg;

  // Pad drive and pulls
  logic [39:0] out_next, oe_next, up_next, down_next;
  logic        src;

  always_comb begin
    src = 1'b0;
    for (int i = 0; i < NPIN; i++) begin
      // (R1) per-pin function decode; (R19) codes
      case (fn_reg[i])
        gpio_pin_pkg::FN_ALT: begin
          // (R12) (R14) (R18) alternate owns pin
          out_next[i] = ALT_OUT_IN[i];
          oe_next[i]  = ALT_OE_IN[i];
        end
        gpio_pin_pkg::FN_DSP: begin
          out_next[i] = DSP_OUT_IN[i];
          oe_next[i]  = DSP_OE_IN[i];
        end
        default: begin
          case (fn_reg[i])
            gpio_pin_pkg::FN_LOGIC: src = lvl_reg[i];
            gpio_pin_pkg::FN_IRQ1:  src = EDGE_IRQ_OUT;
            gpio_pin_pkg::FN_IRQ2:  src = IRQ2_IN;
            default:                src = FUNC_SRC_IN[i];
          endcase
          // (R9) (R11) level with invert
          out_next[i] = src ^ pol_reg[i];
          // (R13) (R18) open drain releases high
          oe_next[i]  = !dir_reg[i] && !(od_reg[i] && out_next[i]);
        end
      endcase
      // (R6) (R7) keeper steers pulls to last level
      up_next[i]   = pu_reg[i] && (!pd_reg[i] || level_in[i]);
      down_next[i] = pd_reg[i] && (!pu_reg[i] || !level_in[i]);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      PIN_OUT       <= 40'h00_0000_0000;
      PIN_OE_OUT    <= 40'h00_0000_0000;
      PULL_UP_OUT   <= 40'h00_0000_0000;
      PULL_DOWN_OUT <= 40'h00_0000_0000;
    end else begin
      PIN_OUT       <= out_next;
      PIN_OE_OUT    <= oe_next;
      PULL_UP_OUT   <= up_next;
      PULL_DOWN_OUT <= down_next;
    end
  end

  // Register read path
  logic [15:0] rdata_next;
  logic [5:0]  ridx;

  assign ridx = pin_index(REG_ADDR_IN);

  always_comb begin
    rdata_next = 16'h0000;
    if (ctrl_hit(REG_ADDR_IN) && !REG_ADDR_IN[0]) begin
      // (R2) filtered level, no invert; (R10) output reads 0
      rdata_next = {dir_reg[ridx] && level_in[ridx], od_reg[ridx], db_reg[ridx],
                    pol_reg[ridx], 3'h0, fn_reg[ridx]};
    end else if (ctrl_hit(REG_ADDR_IN)) begin
      rdata_next = {dir_reg[ridx], pu_reg[ridx], pd_reg[ridx], 13'h0000};
    end else if (REG_ADDR_IN == `GPIO_DBCFG_ADDR) begin
      rdata_next = {12'h000, dbtime_reg};
    end else if (REG_ADDR_IN == `GPIO_FLAG_ADDR0) begin
      rdata_next = flag_reg[15:0];
    end else if (REG_ADDR_IN == `GPIO_FLAG_ADDR1) begin
      rdata_next = flag_reg[31:16];
    end else if (REG_ADDR_IN == `GPIO_FLAG_ADDR2) begin
      rdata_next = {8'h00, flag_reg[39:32]};
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      REG_RDATA_OUT  <= 16'h0000;
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= REG_RD_IN;
      if (REG_RD_IN) begin
        REG_RDATA_OUT <= rdata_next;
      end
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  for (genvar g = 0; g < NPIN; g++) begin : g_chk
    logic_drive_a: assert property ( // (R11)
      fn_reg[g] == gpio_pin_pkg::FN_LOGIC && !dir_reg[g] && !od_reg[g] |=>
        PIN_OE_OUT[g] && PIN_OUT[g] == $past(lvl_reg[g] ^ pol_reg[g]))
      else $error("logic output does not match level and invert");
    alt_pass_a: assert property ( // (R12)
      fn_reg[g] == gpio_pin_pkg::FN_ALT |=>
        PIN_OUT[g] == $past(ALT_OUT_IN[g]) && PIN_OE_OUT[g] == $past(ALT_OE_IN[g]))
      else $error("alternate function not passed straight through");
    open_drain_a: assert property ( // (R13)
      fn_reg[g] == gpio_pin_pkg::FN_LOGIC && !dir_reg[g] && od_reg[g] |=>
        PIN_OE_OUT[g] == !PIN_OUT[g])
      else $error("open drain drove a high level");
    input_hiz_a: assert property ( // (R18)
      fn_reg[g] == gpio_pin_pkg::FN_LOGIC && dir_reg[g] |=> !PIN_OE_OUT[g])
      else $error("input pin is driven");
    keeper_pull_a: assert property ( // (R7)
      pu_reg[g] && pd_reg[g] |=> PULL_UP_OUT[g] != PULL_DOWN_OUT[g])
      else $error("keeper must enable exactly one pull");
    edge_flag_a: assert property ( // (R4)
      $changed(level_in[g]) |=> flag_reg[g])
      else $error("pin edge did not set its flag");
    flag_hold_a: assert property ( // (R5)
      flag_reg[g] && !clr[g] |=> flag_reg[g] ##0 EDGE_IRQ_OUT)
      else $error("latched flag dropped without a clear");
  end

  reset_keeper_a: assert property ( // (R8)
    $rose(RESETN_IN) |=> (PULL_UP_OUT | PULL_DOWN_OUT) == 40'hFF_FFFF_FFFF)
    else $error("keeper not active after reset");

  out_read_a: assert property ( // (R10)
    REG_RD_IN && ctrl_hit(REG_ADDR_IN) && !REG_ADDR_IN[0] && !dir_reg[ridx] |=>
      !REG_RDATA_OUT[15])
    else $error("output level bit read back nonzero");

endmodule // gpio_pin_control

// ==== bench/gpio_pad_model.sv ====
// Pad model: external drivers, pulls and keeper on the 40 pins
`timescale 1ns/1ps
module gpio_pad_model (
  // Clock
  input  wire logic        clk_in,
  // Device side of the pads
  input  wire logic [39:0] pin_out_in,
  input  wire logic [39:0] pin_oe_in,
  input  wire logic [39:0] pull_up_in,
  input  wire logic [39:0] pull_down_in,
  // External drivers
  input  wire logic [39:0] ext_val_in,
  input  wire logic [39:0] ext_oe_in,
  // Resolved pad level
  output logic      [39:0] pad_out
);
  logic [39:0] last_reg = '0;

  always_ff @(posedge clk_in) begin
    last_reg <= pad_out;
  end

  always_comb begin
    for (int i = 0; i < 40; i++) begin
      if (pin_oe_in[i]) begin
        pad_out[i] = pin_out_in[i];
      end else if (ext_oe_in[i]) begin
        pad_out[i] = ext_val_in[i];
      end else if (pull_up_in[i] && pull_down_in[i]) begin
        pad_out[i] = last_reg[i];
      end else if (pull_up_in[i] || pull_down_in[i]) begin
        pad_out[i] = pull_up_in[i];
      end else begin
        pad_out[i] = ~last_reg[i];
      end
    end
  end
endmodule // gpio_pad_model

// ==== bench/gpio_pin_control_tb.sv ====
// Self-checking bench for the pin control block
`timescale 1ns/1ps
`include "gpio_pin_regs.svh"
module gpio_pin_control_tb;
  logic        clk;
  logic        rstn;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic        wr_s;
  logic        rd_s;
  logic [15:0] rdata;
  logic        rvalid;
  logic [39:0] pin_in;
  logic [39:0] pin_out;
  logic [39:0] pin_oe;
  logic [39:0] pull_up;
  logic [39:0] pull_down;
  logic [39:0] alt_out;
  logic [39:0] alt_oe;
  logic [39:0] dsp_out;
  logic [39:0] dsp_oe;
  logic [39:0] func_src;
  logic        irq2;
  logic [39:0] level;
  logic        edge_irq;
  logic [39:0] ext_val;
  logic [39:0] ext_oe;
  logic [15:0] rv;
  int          err_total;
  int          check_count;
  int          tick;
  int          dbt;

  gpio_pin_control gpio_pin_control_i (
    .CLK_IN(clk), .RESETN_IN(rstn), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_OUT(pin_oe), .PULL_UP_OUT(pull_up),
    .PULL_DOWN_OUT(pull_down), .ALT_OUT_IN(alt_out), .ALT_OE_IN(alt_oe),
    .DSP_OUT_IN(dsp_out), .DSP_OE_IN(dsp_oe), .FUNC_SRC_IN(func_src), .IRQ2_IN(irq2),
    .PIN_LEVEL_OUT(level), .EDGE_IRQ_OUT(edge_irq)
  );

  gpio_pad_model gpio_pad_model_i (
    .clk_in(clk), .pin_out_in(pin_out), .pin_oe_in(pin_oe), .pull_up_in(pull_up),
    .pull_down_in(pull_down), .ext_val_in(ext_val), .ext_oe_in(ext_oe), .pad_out(pin_in)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chkb(input logic seen, input logic exp);
    check({39'h0, seen}, {39'h0, exp});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask

  // Read data is taken on the first settled view of the valid pulse
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    int n;
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 3) begin
      @(negedge clk);
      n++;
    end
    if (rvalid !== 1'b1) begin
      err_total++;
      $display("BAD t=%0t rvalid=%h exp=1", $time, rvalid);
    end
    d = rdata;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    check({24'h0, d}, {24'h0, exp});
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Tests need about 50000 cycles, most of it debounce waits
  initial begin
    repeat (80000) @(posedge clk);
    err_total++;
    finish_test();
  end

  initial begin
    err_total = 0;
    check_count = 0;
    rstn = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
    wr_s = 1'b0;
    rd_s = 1'b0;
    alt_out = '0;
    alt_oe = '0;
    dsp_out = '0;
    dsp_oe = '0;
    func_src = '0;
    irq2 = 1'b0;
    ext_val = '0;
    ext_oe = '0;
    tick = `GPIO_SLOW_DIV;
    dbt = (`GPIO_DB_TIME0_US * `GPIO_SLOW_HZ + `GPIO_US_PER_S - 1) / `GPIO_US_PER_S;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    wait_cyc(10);
    check(pull_down, {40{1'b1}});
    check(pull_up, 40'h0);
    check(pin_oe, 40'h0);
    rchk(16'h1700, 16'h2001);
    rchk(16'h174F, 16'hE000);
    rchk(16'h1AC0, 16'h0000);
    rchk(16'h1750, 16'h0000);
    $display("test reset done");

    wr(16'h1701, 16'h0000);
    wr(16'h1700, 16'h8001);
    wait_cyc(3);
    chkb(pin_out[0], 1'b1);
    chkb(pin_oe[0], 1'b1);
    rchk(16'h1700, 16'h0001);
    wr(16'h1700, 16'h9001);
    wait_cyc(3);
    chkb(pin_out[0], 1'b0);
    wr(16'h1700, 16'h4001);
    wait_cyc(3);
    chkb(pin_oe[0], 1'b1);
    chkb(pin_out[0], 1'b0);
    wr(16'h1700, 16'hC001);
    wait_cyc(3);
    chkb(pin_oe[0], 1'b0);
    wr(16'h1700, 16'h8001);
    $display("test output done");

    wr(16'h1708, 16'h0001);
    wr(16'h1B00, 16'hFFFF);
    wr(16'h1B01, 16'hFFFF);
    wr(16'h1B02, 16'h00FF);
    ext_val[4] = 1'b1;
    ext_oe[4] = 1'b1;
    wait_cyc(8);
    chkb(level[4], 1'b1);
    rchk(16'h1708, 16'h8001);
    wr(16'h1708, 16'h1001);
    rchk(16'h1708, 16'h9001);
    rd(16'h1B00, rv);
    check({24'h0, rv & 16'h0010}, 40'h10);
    chkb(edge_irq, 1'b1);
    wr(16'h1B00, 16'h0010);
    rd(16'h1B00, rv);
    check({24'h0, rv & 16'h0010}, 40'h0);
    ext_val[4] = 1'b0;
    wait_cyc(8);
    rd(16'h1B00, rv);
    check({24'h0, rv & 16'h0010}, 40'h10);
    ext_val[4] = 1'b1;
    wait_cyc(8);
    ext_oe[4] = 1'b0;
    wait_cyc(8);
    chkb(level[4], 1'b1);
    wr(16'h1709, 16'hA000);
    wait_cyc(8);
    chkb(level[4], 1'b0);
    chkb(pull_up[4], 1'b0);
    wr(16'h1709, 16'hC000);
    wait_cyc(8);
    chkb(level[4], 1'b1);
    chkb(pull_down[4], 1'b0);
    $display("test input done");

    alt_oe[1] = 1'b1;
    dsp_out[1] = 1'b1;
    dsp_oe[1] = 1'b1;
    irq2 = 1'b1;
    func_src[2] = 1'b1;
    wr(16'h1702, 16'h5000);
    wait_cyc(3);
    chkb(pin_out[1], 1'b0);
    chkb(pin_oe[1], 1'b1);
    wr(16'h1702, 16'h5002);
    wait_cyc(3);
    chkb(pin_out[1], 1'b1);
    chkb(pin_oe[1], 1'b1);
    wr(16'h1705, 16'h0000);
    wr(16'h1704, 16'h0003);
    wait_cyc(3);
    chkb(pin_out[2], 1'b1);
    wr(16'h1704, 16'h1003);
    wait_cyc(3);
    chkb(pin_out[2], 1'b0);
    wr(16'h1704, 16'h0004);
    wait_cyc(3);
    chkb(pin_out[2], 1'b1);
    irq2 = 1'b0;
    wait_cyc(3);
    chkb(pin_out[2], 1'b0);
    wr(16'h1704, 16'h1010);
    wait_cyc(3);
    chkb(pin_out[2], 1'b0);
    chkb(pin_out[0], 1'b1);
    $display("test function done");

    // Reserved code falls back to the shortest period
    wr(16'h1AC0, 16'h000B);
    rchk(16'h1AC0, 16'h000B);
    ext_val[5] = 1'b1;
    ext_oe[5] = 1'b1;
    wait_cyc(200);
    chkb(level[5], 1'b0);
    ext_val[5] = 1'b0;
    wait_cyc(6 * tick);
    chkb(level[5], 1'b0);
    rd(16'h1B00, rv);
    check({24'h0, rv & 16'h0020}, 40'h0);
    ext_val[5] = 1'b1;
    wait_cyc(dbt * tick);
    chkb(level[5], 1'b0);
    wait_cyc(2 * tick);
    chkb(level[5], 1'b1);
    rd(16'h1B00, rv);
    check({24'h0, rv & 16'h0020}, 40'h20);
    $display("test debounce done");
    finish_test();
  end
endmodule // gpio_pin_control_tb
